// File: rtl/dcpia_pkg.sv
// shared constants and types for the potentiometer serial register block
package dcpia_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_WIPER    = 8'h00;
   localparam logic [7:0] ADDR_RESERVED = 8'h01;
   localparam logic [7:0] ADDR_ACCESS   = 8'h02;
   localparam logic [7:0] ACCESS_RESET  = 8'h00;
   localparam logic [7:0] ACCESS_VOLATILE = 8'h80;
   localparam int         ACCESS_SEL_BIT = 7;
   localparam logic [6:0] WIPER_RESET   = 7'h40;
   // ---------------------------------------------------------------
   // identification byte
   // ---------------------------------------------------------------
   localparam int         ID_TYPE_W     = 5;
   localparam logic [4:0] ID_TYPE_CODE  = 5'h0b; // arbitrary value
   localparam logic [2:0] BIT_LAST      = 3'h7;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      DCPIA_IDLE, DCPIA_ID, DCPIA_ADDR, DCPIA_DATA, DCPIA_TX, DCPIA_ACK, DCPIA_MACK, DCPIA_SKIP
   } dcpia_state_e;
   typedef struct packed {
      logic req;
      logic [7:0] data;
   } dcpia_nvreq_s;
endpackage

// File: rtl/dcpia_top.sv
// serial target and register logic of a single potentiometer
//
// Behaviour
// - nonvolatile write starts only on stop
// - valid id, address and clock count required
// - data shifts in before any register changes
// - address 0 or 2 loads on last falling edge
// - ack three command bytes, send data msb first
// - access register selects volatile or stored read
// - access register is 8 bits, msb significant
// - 00h maps stored value, 80h maps wiper
// - access register resets to 00h
// - writing stored value also loads wiper
// - reading stored value leaves wiper alone
// - power-up copies stored value into wiper
// - id matches type code and select pins
// - ignore lines during nonvolatile write cycle
// - wiper is seven bits, monotonic position
`timescale 1ns/1ns
module dcpia_top (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // serial pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       addr_select_hi_i,
   input  wire logic       addr_select_lo_i,
   // nonvolatile storage
   input  wire logic [7:0] nv_value_i,
   input  wire logic       nv_valid_i,
   output logic            nv_req_o,
   output logic [7:0]      nv_data_o,
   input  wire logic       nv_done_i,
   // wiper and access register
   output logic [6:0]      wiper_o,
   output logic [7:0]      access_select_o
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // a level counts once the second and third stages agree, so one-cycle glitches are dropped
   logic [2:0] scl_sync_q;
   logic [2:0] sda_sync_q;
   logic       scl_q;
   logic       sda_q;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_i};
         sda_sync_q <= {sda_sync_q[1:0], sda_i};
         if (scl_sync_q[1] == scl_sync_q[2]) begin
            scl_q <= scl_sync_q[2];
         end
         if (sda_sync_q[1] == sda_sync_q[2]) begin
            sda_q <= sda_sync_q[2];
         end
      end
   end
   logic scl_f_q;
   logic sda_f_q;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
      end else begin
         scl_f_q <= scl_q;
         sda_f_q <= sda_q;
      end
   end
   // start and stop need the clock high on both samples, so a data move at a clock edge is not misread
   wire scl_rise = scl_q & ~scl_f_q;
   wire scl_fall = ~scl_q & scl_f_q;
   wire start_ev = scl_q & scl_f_q & sda_f_q & ~sda_q;
   wire stop_ev  = scl_q & scl_f_q & ~sda_f_q & sda_q;
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   dcpia_pkg::dcpia_state_e state_q, state_d;
   logic [7:0] shift_q;
   logic [2:0] bit_q;
   logic [7:0] addr_q;
   logic [7:0] access_q;
   logic [6:0] wiper_q;
   logic [7:0] stored_q;
   logic       rd_q;
   logic       ack_ok_q;
   logic       nv_pend_q;
   logic       nv_busy_q;
   logic       recall_q;
   logic       sda_drv_q;
   logic [7:0] tx_q;
   // phase that follows an acknowledge, known from the byte count
   logic [1:0] phase_q;
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire [7:0] shift_in  = {shift_q[6:0], sda_q};
   wire       byte_done = scl_rise & (bit_q == dcpia_pkg::BIT_LAST);
   // the direction bit is not part of the match; it is kept when the byte is taken
   wire       id_match  = shift_in[7:3] == dcpia_pkg::ID_TYPE_CODE
                          && shift_in[2] == addr_select_hi_i
                          && shift_in[1] == addr_select_lo_i;
   wire       addr_ok   = shift_in == dcpia_pkg::ADDR_WIPER
                          || shift_in == dcpia_pkg::ADDR_ACCESS;
   wire       volatile_sel = access_q[dcpia_pkg::ACCESS_SEL_BIT];
   wire [7:0] read_value = (addr_q == dcpia_pkg::ADDR_ACCESS) ? access_q :
                           volatile_sel ? {1'b0, wiper_q} : stored_q;
   // copy on the fall that ends the data lsb; a stop or start before it leaves every register alone
   // a data byte cut short never reaches this point
   wire       load_data = (state_q == dcpia_pkg::DCPIA_ACK) && scl_fall && !sda_drv_q && ack_ok_q;
   // nothing on the lines counts while the stored value is busy
   wire       bus_live  = ~nv_busy_q & ~recall_q;
   // ---------------------------------------------------------------
   // transaction state machine
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      if (!bus_live) begin
         state_d = dcpia_pkg::DCPIA_IDLE;
      end else if (start_ev) begin
         state_d = dcpia_pkg::DCPIA_ID;
      end else if (stop_ev) begin
         state_d = dcpia_pkg::DCPIA_IDLE;
      end else begin
         unique case (state_q)
            dcpia_pkg::DCPIA_IDLE: state_d = dcpia_pkg::DCPIA_IDLE;
            dcpia_pkg::DCPIA_ID: begin
               if (byte_done) begin
                  state_d = id_match ? dcpia_pkg::DCPIA_ACK : dcpia_pkg::DCPIA_SKIP;
               end
            end
            dcpia_pkg::DCPIA_ADDR: begin
               if (byte_done) begin
                  state_d = addr_ok ? dcpia_pkg::DCPIA_ACK : dcpia_pkg::DCPIA_SKIP;
               end
            end
            dcpia_pkg::DCPIA_DATA: begin
               if (byte_done) begin
                  state_d = dcpia_pkg::DCPIA_ACK;
               end
            end
            dcpia_pkg::DCPIA_ACK: begin
               // the first fall starts the acknowledge, the second ends it and picks the next phase
               if (scl_fall && sda_drv_q) begin
                  if (rd_q) begin
                     state_d = dcpia_pkg::DCPIA_TX;
                  end else if (phase_q == 2'h1) begin
                     state_d = dcpia_pkg::DCPIA_ADDR;
                  end else begin
                     state_d = dcpia_pkg::DCPIA_DATA;
                  end
               end
            end
            dcpia_pkg::DCPIA_TX: begin
               if (scl_fall && bit_q == dcpia_pkg::BIT_LAST) begin
                  state_d = dcpia_pkg::DCPIA_MACK;
               end
            end
            dcpia_pkg::DCPIA_MACK: begin
               if (scl_fall) begin
                  state_d = dcpia_pkg::DCPIA_SKIP;
               end
            end
            // a refused byte parks here until the next start or stop
            dcpia_pkg::DCPIA_SKIP: state_d = dcpia_pkg::DCPIA_SKIP;
         endcase
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q  <= dcpia_pkg::DCPIA_IDLE;
         phase_q  <= 2'h0;
         bit_q    <= 3'h0;
         shift_q  <= 8'h00;
         rd_q     <= 1'b0;
         addr_q   <= dcpia_pkg::ADDR_WIPER;
         ack_ok_q <= 1'b0;
         sda_drv_q <= 1'b0;
         tx_q     <= 8'h00;
      end else begin
         state_q <= state_d;
         if (state_q == dcpia_pkg::DCPIA_ACK && scl_fall) begin
            if (!sda_drv_q) begin
               // eighth bit done: pull the line low for the acknowledge
               sda_drv_q <= 1'b1;
            end else begin
               // leaving the acknowledge slot
               sda_drv_q <= 1'b0;
               bit_q     <= 3'h0;
               ack_ok_q  <= 1'b0;
               if (rd_q) begin
                  tx_q      <= read_value;
                  sda_drv_q <= ~read_value[7];
               end
            end
         end
         if (start_ev && bus_live) begin
            bit_q    <= 3'h0;
            phase_q  <= 2'h0;
            ack_ok_q <= 1'b0;
         end
         if (scl_rise && (state_q == dcpia_pkg::DCPIA_ID || state_q == dcpia_pkg::DCPIA_ADDR
                          || state_q == dcpia_pkg::DCPIA_DATA)) begin
            shift_q <= shift_in;
            bit_q   <= bit_q + 3'h1;
         end
         if (byte_done && state_d == dcpia_pkg::DCPIA_ACK) begin
            phase_q <= phase_q + 2'h1;
            if (state_q == dcpia_pkg::DCPIA_ID) begin
               rd_q <= shift_in[0];
            end
            if (state_q == dcpia_pkg::DCPIA_ADDR) begin
               addr_q <= shift_in;
            end
            if (state_q == dcpia_pkg::DCPIA_DATA) begin
               ack_ok_q <= 1'b1;
            end
         end
         // each fall moves to the next bit; the line is let go after the lsb for the master's answer
         if (state_q == dcpia_pkg::DCPIA_TX && scl_fall) begin
            bit_q     <= bit_q + 3'h1;
            tx_q      <= {tx_q[6:0], 1'b0};
            sda_drv_q <= (bit_q != dcpia_pkg::BIT_LAST) & ~tx_q[6];
         end
         if (!bus_live || stop_ev) begin
            sda_drv_q <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // register updates
   // ---------------------------------------------------------------
   wire load_wiper  = load_data && addr_q == dcpia_pkg::ADDR_WIPER;
   wire load_access = load_data && addr_q == dcpia_pkg::ADDR_ACCESS;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         access_q  <= dcpia_pkg::ACCESS_RESET;
         wiper_q   <= dcpia_pkg::WIPER_RESET;
         stored_q  <= 8'h00;
         nv_pend_q <= 1'b0;
         nv_busy_q <= 1'b0;
         recall_q  <= 1'b1;
      end else begin
         // the stored value is unknown until recall, so the bus stays deaf until then
         // a recall that never comes keeps the wiper at mid scale
         if (recall_q && nv_valid_i) begin
            recall_q <= 1'b0;
            stored_q <= nv_value_i;
            wiper_q  <= nv_value_i[6:0];
         end
         if (load_access) begin
            access_q <= shift_q;
         end
         if (load_wiper) begin
            wiper_q <= shift_q[6:0];
            if (!volatile_sel) begin
               stored_q  <= shift_q;
               nv_pend_q <= 1'b1;
            end
         end
         if (start_ev) begin
            nv_pend_q <= 1'b0;
         end
         // only a stop commits; the storage side may take as long as it needs
         if (stop_ev && nv_pend_q && bus_live) begin
            nv_pend_q <= 1'b0;
            nv_busy_q <= 1'b1;
         end
         if (nv_busy_q && nv_done_i) begin
            nv_busy_q <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // open drain: the pad only ever pulls low, the enable carries the data
   // the bus pull-up gives the high level
   assign sda_o           = 1'b0;
   assign sda_oe_o        = sda_drv_q;
   assign nv_req_o        = nv_busy_q;
   assign nv_data_o       = stored_q;
   assign wiper_o         = wiper_q;
   assign access_select_o = access_q;
endmodule

// File: verif/dcpia_master.sv
// serial bus master model that drives the clock line
`timescale 1ns/1ns
module dcpia_master (
   // clock
   input  wire logic clock_i,
   // serial lines
   output logic      scl_o,
   output logic      sda_pull_o,
   input  wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // phases of ten clocks leave room for the target's sync latency
   task automatic half();
      repeat (10) @(negedge clock_i);
   endtask
   task automatic start();
      sda_pull_o = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      sda_pull_o = 1'b1;
      half();
      scl_o = 1'b0;
   endtask
   task automatic stop();
      sda_pull_o = 1'b1;
      half();
      scl_o = 1'b1;
      half();
      sda_pull_o = 1'b0;
      half();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_pull_o = ~b;
      half();
      scl_o = 1'b1;
      half();
      r = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, r);
   endtask
endmodule

// File: verif/dcpia_top_asserts.sv
// port checks for the potentiometer serial block
`timescale 1ns/1ns
module dcpia_top_asserts (
   // clock and reset
   input wire logic       clock_i,
   input wire logic       rst_n_i,
   // serial and storage
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_oe_o,
   input wire logic       nv_req_o,
   input wire logic [7:0] nv_data_o,
   input wire logic       nv_done_i,
   // registers
   input wire logic [6:0] wiper_o,
   input wire logic [7:0] access_select_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_hold; nv_req_o && !nv_done_i |=> nv_req_o && $stable(nv_data_o); endproperty
   a_hold: assert property (p_hold) else $error("store request dropped");
   property p_drop; nv_req_o && nv_done_i |=> !nv_req_o; endproperty
   a_drop: assert property (p_drop) else $error("store request held");
   property p_quiet; nv_req_o |-> !sda_oe_o; endproperty
   a_quiet: assert property (p_quiet) else $error("drive while busy");
   property p_cause; $rose(nv_req_o) |-> scl_i && sda_i && access_select_o == 8'h00; endproperty
   a_cause: assert property (p_cause) else $error("store without stop");
   property p_same; $rose(nv_req_o) |-> wiper_o == nv_data_o[6:0]; endproperty
   a_same: assert property (p_same) else $error("wiper differs");
   property p_acc; !$stable(access_select_o) |-> !scl_i; endproperty
   a_acc: assert property (p_acc) else $error("access load off edge");
   property p_drv; !$stable(sda_oe_o) |-> !scl_i; endproperty
   a_drv: assert property (p_drv) else $error("data moved in clock high");
   property p_rst; $rose(rst_n_i) |-> access_select_o == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("access reset");
   c_store: cover property ($rose(nv_req_o));
   c_ack: cover property ($rose(sda_oe_o));
   c_acc: cover property (!$stable(access_select_o));
endmodule
bind dcpia_top dcpia_top_asserts i_dcpia_top_asserts (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_oe_o(sda_oe_o), .nv_req_o(nv_req_o), .nv_data_o(nv_data_o), .nv_done_i(nv_done_i),
   .wiper_o(wiper_o), .access_select_o(access_select_o));

// File: verif/dcpia_top_tb.sv
// self-checking bench for the potentiometer serial block
`timescale 1ns/1ns
module dcpia_top_tb;
   localparam logic [6:0] ID = {dcpia_pkg::ID_TYPE_CODE, 2'b10};
   logic       clock_i, scl, pull, oe, nv_req, ok;
   logic       rst_n_i = 1'b0;
   logic       nv_valid = 1'b0;
   logic       nv_done = 1'b0;
   logic [7:0] nv_value = 8'h2a;
   logic [7:0] nv_data, access, d;
   logic [6:0] wiper;
   int         n_errors, checked, cycles, nv_cnt;
   wire        sda = ~(oe | pull);
   dcpia_top i_dcpia_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_o(oe), .addr_select_hi_i(1'b1), .addr_select_lo_i(1'b0), .nv_value_i(nv_value),
      .nv_valid_i(nv_valid), .nv_req_o(nv_req), .nv_data_o(nv_data), .nv_done_i(nv_done),
      .wiper_o(wiper), .access_select_o(access));
   dcpia_master i_dcpia_master (.clock_i(clock_i), .scl_o(scl), .sda_pull_o(pull), .sda_i(sda));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   // slow storage so the busy window can be probed
   always @(negedge clock_i) begin
      nv_done <= 1'b0;
      nv_cnt <= nv_req ? nv_cnt + 1 : 0;
      if (nv_cnt == 500) begin
         nv_done <= 1'b1;
         nv_value <= nv_data;
      end
   end
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic k);
      logic k1, k2, k3;
      i_dcpia_master.start();
      i_dcpia_master.send({ID, 1'b0}, k1);
      i_dcpia_master.send(a, k2);
      i_dcpia_master.send(v, k3);
      i_dcpia_master.stop();
      k = k1 & k2 & k3;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic k);
      logic k1, k2, k3;
      i_dcpia_master.start();
      i_dcpia_master.send({ID, 1'b0}, k1);
      i_dcpia_master.send(a, k2);
      i_dcpia_master.start();
      i_dcpia_master.send({ID, 1'b1}, k3);
      i_dcpia_master.recv(v);
      i_dcpia_master.stop();
      k = k1 & k2 & k3;
   endtask
   task automatic wait_req(input logic lvl);
      for (int i = 0; i < 700 && nv_req !== lvl; i++) @(negedge clock_i);
   endtask
   initial begin
      repeat (16) @(negedge clock_i);
      rst_n_i = 1'b1;
      check({1'b0, access}, 9'h000);
      check({2'h0, wiper}, {2'h0, dcpia_pkg::WIPER_RESET});
      nv_valid = 1'b1;
      repeat (8) @(negedge clock_i);
      check({2'h0, wiper}, 9'h02a);
      i_dcpia_master.start();
      i_dcpia_master.send({dcpia_pkg::ID_TYPE_CODE, 3'h2}, ok);
      i_dcpia_master.stop();
      check({ok, 1'b0, wiper}, 9'h02a);
      wr(8'h02, 8'h80, ok);
      check({ok, access}, 9'h180);
      wr(8'h00, 8'h55, ok);
      check({ok, nv_req, wiper}, 9'h155);
      rd(8'h00, d, ok);
      check({ok, d}, 9'h155);
      rd(8'h02, d, ok);
      check({ok, d}, 9'h180);
      wr(8'h01, 8'h33, ok);
      check({ok, 1'b0, wiper}, 9'h055);
      i_dcpia_master.start();
      i_dcpia_master.send({ID, 1'b0}, ok);
      i_dcpia_master.send(8'h00, ok);
      for (int i = 0; i < 5; i++) i_dcpia_master.bit_io(1'b0, ok);
      i_dcpia_master.stop();
      check({nv_req, 1'b0, wiper}, 9'h055);
      wr(8'h02, 8'h00, ok);
      wr(8'h00, 8'h77, ok);
      check({ok, 1'b0, wiper}, 9'h177);
      wait_req(1'b1);
      check({nv_req, nv_data}, 9'h177);
      i_dcpia_master.start();
      i_dcpia_master.send({ID, 1'b0}, ok);
      i_dcpia_master.stop();
      check({7'h00, ok, nv_req}, 9'h001);
      wait_req(1'b0);
      check({nv_req, nv_value}, 9'h077);
      wr(8'h02, 8'h80, ok);
      wr(8'h00, 8'h11, ok);
      check({ok, nv_req, wiper}, 9'h111);
      wr(8'h02, 8'h00, ok);
      rd(8'h00, d, ok);
      check({ok, d}, 9'h177);
      check({2'h0, wiper}, 9'h011);
      final_report();
   end
endmodule
